/* core/aitu_core.sv */
`timescale 1ns/1ps
`include "aitu_defs.svh"
module aitu_core (
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_start,
	input  wire logic [3:0]  i_op,
	input  wire logic [2:0]  i_mode,
	input  wire logic [7:0]  i_acc,
	input  wire logic [7:0]  i_breg,
	input  wire logic [7:0]  i_operand,
	input  wire logic [15:0] i_data_ptr,
	input  wire logic        i_carry,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_illegal,
	output logic      [1:0]  o_bytes,
	output logic      [7:0]  o_result,
	output logic      [7:0]  o_result_hi,
	output logic      [15:0] o_data_ptr,
	output logic      [2:0]  o_flags
);
	aitu_pkg::aitu_state_t state;
	logic [2:0]  tbl_cycles;
	logic [1:0]  tbl_bytes;
	logic        tbl_legal;
	logic [2:0]  remain;
	logic [7:0]  next_res;
	logic [7:0]  next_hi;
	logic [15:0] next_data_ptr;
	logic [2:0]  next_flags;
	logic        take;

	aitu_timing u_timing (
		.i_op     (i_op),
		.i_mode   (i_mode),
		.o_cycles (tbl_cycles),
		.o_bytes  (tbl_bytes),
		.o_legal  (tbl_legal)
	);

	// Requests during a busy instruction are ignored, so the next cannot overlap.
	assign take = i_start && (state != aitu_pkg::AITU_BUSY);

	// Shared adder for sum, carry-sum and borrow-subtract; returns {cy, ac, ov, res}.
	function automatic logic [10:0] addsub(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic sub);
		logic [8:0] full;
		logic [4:0] low;
		logic [7:0] bb;
		bb   = sub ? ~b : b;
		full = {1'b0, a} + {1'b0, bb} + {8'h00, sub ^ cin};
		low  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub ^ cin};
		addsub = {full[8] ^ sub, low[4] ^ sub, (a[7] == bb[7]) && (full[7] != a[7]), full[7:0]};
	endfunction

	always_comb begin
		logic [10:0] s;
		logic [15:0] prod;
		logic [8:0]  adj;
		s          = 11'h000;
		prod       = 16'h0000;
		adj        = 9'h000;
		next_res   = i_acc;
		next_hi    = 8'h00;
		next_data_ptr = i_data_ptr;
		next_flags = {i_carry, 2'b00};
		case (i_op)
			`AITU_OP_ADD, `AITU_OP_SUMC, `AITU_OP_SUBW: begin
				s = addsub(i_acc, i_operand, (i_op != `AITU_OP_ADD) && i_carry,
					i_op == `AITU_OP_SUBW);
				next_res   = s[7:0];
				next_flags = s[10:8];
			end
			`AITU_OP_INC: begin
				next_res = ((i_mode == `AITU_MODE_ACC) ? i_acc : i_operand) + 8'h01;
			end
			`AITU_OP_MINUS: begin
				next_res = ((i_mode == `AITU_MODE_ACC) ? i_acc : i_operand) - 8'h01;
			end
			`AITU_OP_INCDP: begin
				next_data_ptr = i_data_ptr + 16'h0001;
			end
			`AITU_OP_PROD: begin
				prod       = {8'h00, i_acc} * {8'h00, i_breg};
				next_res   = prod[7:0];
				next_hi    = prod[15:8];
				next_flags = {1'b0, 1'b0, prod[15:8] != 8'h00};
			end
			`AITU_OP_DIV: begin
				// Division by zero leaves operands and raises overflow, as is customary.
				if (i_breg == 8'h00) begin
					next_hi    = i_breg;
					next_flags = 3'b001;
				end else begin
					next_res   = i_acc / i_breg;
					next_hi    = i_acc % i_breg;
					next_flags = 3'b000;
				end
			end
			`AITU_OP_DA: begin
				adj = {1'b0, i_acc};
				if (adj[3:0] > 4'h9) begin
					adj = adj + 9'h006;
				end
				if (i_carry || adj[8] || (adj[7:4] > 4'h9)) begin
					adj = adj + 9'h060;
				end
				next_res   = adj[7:0];
				next_flags = {i_carry | adj[8], 2'b00};
			end
			default: begin
				next_res = i_acc;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state  <= aitu_pkg::AITU_IDLE;
			remain <= 3'h0;
		end else begin
			case (state)
				aitu_pkg::AITU_IDLE, aitu_pkg::AITU_DONE: begin
					if (take && tbl_legal) begin
						state  <= aitu_pkg::AITU_BUSY;
						remain <= tbl_cycles - 3'h1;
					end else begin
						state <= aitu_pkg::AITU_IDLE;
					end
				end
				aitu_pkg::AITU_BUSY: begin
					if (remain == 3'h0) begin
						state <= aitu_pkg::AITU_DONE;
					end else begin
						remain <= remain - 3'h1;
					end
				end
				default: begin
					state <= aitu_pkg::AITU_IDLE;
				end
			endcase
		end
	end

	// Results are captured at acceptance; inputs may change while busy.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_result    <= 8'h00;
			o_result_hi <= 8'h00;
			o_data_ptr  <= 16'h0000;
			o_flags     <= 3'h0;
			o_bytes     <= 2'h0;
		end else if (take && tbl_legal) begin
			o_result    <= next_res;
			o_result_hi <= next_hi;
			o_data_ptr  <= next_data_ptr;
			o_flags     <= next_flags;
			o_bytes     <= tbl_bytes;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
			o_illegal <= 1'b0;
		end else begin
			o_illegal <= take && !tbl_legal;
			o_done    <= (state == aitu_pkg::AITU_BUSY) && (remain == 3'h0);
			o_busy    <= (take && tbl_legal)
				|| ((state == aitu_pkg::AITU_BUSY) && (remain != 3'h0));
		end
	end

	a_div_six_cycles: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && tbl_legal && i_op == `AITU_OP_DIV) |=> o_busy [*6] ##1 o_done)
		else $error("Quotient did not take six cycles.");
	a_prod_two_cycles: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && tbl_legal && i_op == `AITU_OP_PROD) |=> o_busy [*2] ##1 (o_done && !o_busy))
		else $error("Product did not take two cycles.");
	a_da_three_cycles: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && tbl_legal && i_op == `AITU_OP_DA) |=> o_busy [*3] ##1 o_done)
		else $error("Decimal adjust did not take three cycles.");
	a_incdir_three: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && i_op == `AITU_OP_INC && i_mode == `AITU_MODE_DIR)
		|=> o_busy [*3] ##1 (o_done && o_bytes == 2'h2))
		else $error("Direct increment timing wrong.");
	a_add_bank_one: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && i_op == `AITU_OP_ADD && i_mode == `AITU_MODE_BANK)
		|=> o_busy ##1 (o_done && !o_busy && o_bytes == 2'h1))
		else $error("Bank sum timing wrong.");
	a_carry_sum_value: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && i_op == `AITU_OP_SUMC && i_mode == `AITU_MODE_IMM)
		|=> (o_result == 8'($past(i_acc) + $past(i_operand) + {7'h00, $past(i_carry)})
		&& o_bytes == 2'h2))
		else $error("Carry sum result wrong.");
	a_borrow_value: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && i_op == `AITU_OP_SUBW && i_mode == `AITU_MODE_IND)
		|=> (o_result == 8'($past(i_acc) - $past(i_operand) - {7'h00, $past(i_carry)})
		&& o_bytes == 2'h1))
		else $error("Borrow subtract result wrong.");
	a_no_overlap: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(state == aitu_pkg::AITU_BUSY && i_start) |=> !o_illegal && $stable(o_result))
		else $error("Request accepted while busy.");
	a_illegal_refused: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && !tbl_legal) |=> (o_illegal && !o_busy && !o_done))
		else $error("Illegal request was not refused.");
	a_done_single: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_done |=> !o_done)
		else $error("Completion pulse stood too long.");
	a_done_not_busy: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_done |-> !o_busy)
		else $error("Busy still high at completion.");
	a_inc_bank_two: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && i_op == `AITU_OP_INC && i_mode == `AITU_MODE_BANK)
		|=> o_busy [*2] ##1 (o_done && o_bytes == 2'h1))
		else $error("Bank increment timing wrong.");
	a_sub_dir_two: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && i_op == `AITU_OP_SUBW && i_mode == `AITU_MODE_DIR)
		|=> o_busy [*2] ##1 (o_done && o_bytes == 2'h2))
		else $error("Direct borrow subtract timing wrong.");
	a_ptr_inc_one: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(take && i_op == `AITU_OP_INCDP)
		|=> o_busy ##1 (o_done && !o_busy && o_bytes == 2'h1))
		else $error("Pointer increment timing wrong.");
endmodule // aitu_core

/* core/aitu_defs.svh */
`ifndef AITU_DEFS_SVH
`define AITU_DEFS_SVH

// Opcode classes presented by the sequencer on i_op.
`define AITU_OP_ADD     4'h0
`define AITU_OP_SUMC    4'h1
`define AITU_OP_SUBW    4'h2
`define AITU_OP_INC     4'h3
`define AITU_OP_MINUS   4'h4
`define AITU_OP_INCDP   4'h5
`define AITU_OP_PROD    4'h6
`define AITU_OP_DIV     4'h7
`define AITU_OP_DA      4'h8

// Addressing forms presented on i_mode.
`define AITU_MODE_ACC   3'h0
`define AITU_MODE_BANK  3'h1
`define AITU_MODE_DIR   3'h2
`define AITU_MODE_IND   3'h3
`define AITU_MODE_IMM   3'h4

// Flag bit positions on o_flags.
`define AITU_FLAG_CY    2
`define AITU_FLAG_AC    1
`define AITU_FLAG_OV    0

// Cycle counts, in machine cycles (one machine cycle is one i_mclk period here).
`define AITU_CYC_1      3'h1
`define AITU_CYC_2      3'h2
`define AITU_CYC_3      3'h3
`define AITU_CYC_6      3'h6

`endif

/* core/aitu_pkg.sv */
package aitu_pkg;
	typedef enum logic [2:0] {
		AITU_IDLE = 3'b001,
		AITU_BUSY = 3'b010,
		AITU_DONE = 3'b100
	} aitu_state_t;
endpackage

/* core/aitu_timing.sv */
`timescale 1ns/1ps
`include "aitu_defs.svh"
// Length and cycle table for each opcode and addressing form.
module aitu_timing (
	input  wire logic [3:0] i_op,
	input  wire logic [2:0] i_mode,
	output logic      [2:0] o_cycles,
	output logic      [1:0] o_bytes,
	output logic            o_legal
);
	always_comb begin
		o_cycles = `AITU_CYC_1;
		o_bytes  = 2'h1;
		o_legal  = 1'b1;
		case (i_op)
			`AITU_OP_ADD, `AITU_OP_SUMC, `AITU_OP_SUBW: begin
				case (i_mode)
					`AITU_MODE_BANK: begin
						o_cycles = `AITU_CYC_1;
					end
					`AITU_MODE_DIR, `AITU_MODE_IMM: begin
						o_cycles = `AITU_CYC_2;
						o_bytes  = 2'h2;
					end
					`AITU_MODE_IND: begin
						o_cycles = `AITU_CYC_2;
					end
					default: begin
						o_legal = 1'b0;
					end
				endcase
			end
			`AITU_OP_INC, `AITU_OP_MINUS: begin
				case (i_mode)
					`AITU_MODE_ACC: begin
						o_cycles = `AITU_CYC_1;
					end
					`AITU_MODE_BANK: begin
						o_cycles = `AITU_CYC_2;
					end
					`AITU_MODE_DIR: begin
						o_cycles = `AITU_CYC_3;
						o_bytes  = 2'h2;
					end
					`AITU_MODE_IND: begin
						o_cycles = `AITU_CYC_3;
					end
					default: begin
						o_legal = 1'b0;
					end
				endcase
			end
			`AITU_OP_INCDP: begin
				o_cycles = `AITU_CYC_1;
			end
			`AITU_OP_PROD: begin
				o_cycles = `AITU_CYC_2;
			end
			`AITU_OP_DIV: begin
				o_cycles = `AITU_CYC_6;
			end
			`AITU_OP_DA: begin
				o_cycles = `AITU_CYC_3;
			end
			default: begin
				o_legal = 1'b0;
			end
		endcase
	end
endmodule // aitu_timing

/* tb/aitu_seq_model.sv */
`timescale 1ns/1ps
// Sequencer side: issues one instruction, then waits for completion.
module aitu_seq_model (
	input  wire logic        i_mclk,
	input  wire logic        i_busy,
	input  wire logic        i_done,
	input  wire logic        i_illegal,
	output logic             o_start,
	output logic      [3:0]  o_op,
	output logic      [2:0]  o_mode,
	output logic      [7:0]  o_acc,
	output logic      [7:0]  o_breg,
	output logic      [7:0]  o_operand,
	output logic      [15:0] o_data_ptr,
	output logic             o_carry
);
	initial begin
		{o_start, o_op, o_mode, o_acc, o_breg, o_operand, o_data_ptr, o_carry} = '0;
	end
	// Operands are only meaningful at the take edge; inverting them after it exposes late sampling.
	task automatic issue(input logic [3:0] op, input logic [2:0] mode, input logic [7:0] a, b, d,
		input logic [15:0] p, input logic c, output int k, output int bn, output logic ill);
		bn = 0;
		@(negedge i_mclk);
		{o_op, o_mode, o_acc, o_breg, o_operand, o_data_ptr, o_carry} = {op, mode, a, b, d, p, c};
		o_start = 1'b1;
		@(negedge i_mclk);
		o_start = 1'b0;
		{o_acc, o_breg, o_operand, o_data_ptr, o_carry} = ~{a, b, d, p, c};
		ill = i_illegal;
		for (k = 0; k < 12; k++) begin
			if (i_done === 1'b1 || ill === 1'b1) break;
			bn += int'(i_busy === 1'b1);
			@(negedge i_mclk);
		end
	endtask
	// A second start, an illegal pair on purpose, lands while the quotient still runs.
	task automatic poke(input logic [7:0] a, b, output int k);
		@(negedge i_mclk);
		{o_op, o_mode, o_acc, o_breg, o_start} = {4'h7, 3'h0, a, b, 1'b1};
		@(negedge i_mclk);
		{o_op, o_acc} = {4'h0, ~a};
		@(negedge i_mclk);
		o_start = 1'b0;
		for (k = 1; k < 12 && i_done !== 1'b1; k++) @(negedge i_mclk);
	endtask
endmodule // aitu_seq_model

/* tb/arith_instr_timing_unit_tb_top.sv */
`timescale 1ns/1ps
module arith_instr_timing_unit_tb_top;
	logic        i_mclk;
	logic        i_sys_rst;
	logic        start;
	logic        carry;
	logic        busy;
	logic        done;
	logic        illegal;
	logic [3:0]  op;
	logic [2:0]  mode;
	logic [7:0]  acc;
	logic [7:0]  breg;
	logic [7:0]  opd;
	logic [7:0]  res;
	logic [7:0]  res_hi;
	logic [15:0] ptr_in;
	logic [15:0] ptr_out;
	logic [1:0]  bytes;
	logic [2:0]  flags;
	int          errors;
	int          checks_done;

	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	aitu_core dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_start(start), .i_op(op),
		.i_mode(mode), .i_acc(acc), .i_breg(breg), .i_operand(opd), .i_data_ptr(ptr_in),
		.i_carry(carry), .o_busy(busy), .o_done(done), .o_illegal(illegal), .o_bytes(bytes),
		.o_result(res), .o_result_hi(res_hi), .o_data_ptr(ptr_out), .o_flags(flags));

	aitu_seq_model seq_u (.i_mclk(i_mclk), .i_busy(busy), .i_done(done), .i_illegal(illegal),
		.o_start(start), .o_op(op), .o_mode(mode), .o_acc(acc), .o_breg(breg),
		.o_operand(opd), .o_data_ptr(ptr_in), .o_carry(carry));

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One instruction; cycles until done, busy cycles and length are judged.
	task automatic run(input logic [3:0] o, input logic [2:0] m, input logic [7:0] a, b, d,
		input logic [15:0] p, input logic c, input int n, input int byt);
		int k;
		int bn;
		logic il;
		seq_u.issue(o, m, a, b, d, p, c, k, bn, il);
		chk("cycles", 16'(k), 16'(n));
		chk("busy_span", 16'(bn), 16'(n));
		chk("bytes", 16'(bytes), 16'(byt));
	endtask

	// Every legal opcode, with every legal form for opcodes 0 to 4 and form 0 only for opcodes 5 to 8, back to back.
	task automatic timing_table;
		for (int o = 0; o < 9; o++) begin
			for (int m = 0; m < 5; m++) begin
				if (o < 3 && m > 0)
					run(4'(o), 3'(m), 8'h01, 8'h01, 8'h01, 16'h0, 1'b0, (m == 1) ? 1 : 2,
						(m == 2 || m == 4) ? 2 : 1);
				else if ((o == 3 || o == 4) && m < 4)
					run(4'(o), 3'(m), 8'h01, 8'h01, 8'h01, 16'h0, 1'b0, (m < 2) ? m + 1 : 3,
						(m == 2) ? 2 : 1);
				else if (o > 4 && m == 0)
					run(4'(o), 3'(m), 8'h01, 8'h01, 8'h01, 16'h0, 1'b0,
						(o == 5) ? 1 : (o == 6) ? 2 : (o == 7) ? 6 : 3, 1);
			end
		end
	endtask

	task automatic results_check;
		run(4'h0, 3'h1, 8'h35, 8'h00, 8'h4a, 16'h0, 1'b0, 1, 1);
		chk("sum", 16'({flags, res}), 16'h007f);
		run(4'h1, 3'h4, 8'hff, 8'h00, 8'h00, 16'h0, 1'b1, 2, 2);
		chk("sum_carry", 16'({flags, res}), 16'h0600);
		run(4'h2, 3'h2, 8'h10, 8'h00, 8'h20, 16'h0, 1'b1, 2, 2);
		chk("sub_borrow", 16'({flags, res}), 16'h06ef);
		run(4'h4, 3'h0, 8'h00, 8'h00, 8'h00, 16'h0, 1'b0, 1, 1);
		chk("minus_one", 16'(res), 16'h00ff);
		run(4'h5, 3'h0, 8'h00, 8'h00, 8'h00, 16'h12ff, 1'b0, 1, 1);
		chk("pointer_inc", ptr_out, 16'h1300);
		run(4'h6, 3'h0, 8'h20, 8'h10, 8'h00, 16'h0, 1'b0, 2, 1);
		chk("product", {res_hi, res}, 16'h0200);
		chk("product_ov", 16'(flags), 16'h0001);
		run(4'h7, 3'h0, 8'h64, 8'h07, 8'h00, 16'h0, 1'b0, 6, 1);
		chk("quotient", {res_hi, res}, 16'h020e);
		run(4'h7, 3'h0, 8'h55, 8'h00, 8'h00, 16'h0, 1'b0, 6, 1);
		chk("div_zero", {res_hi, res}, 16'h0055);
		chk("div_zero_ov", 16'(flags), 16'h0001);
		run(4'h8, 3'h0, 8'h1a, 8'h00, 8'h00, 16'h0, 1'b0, 3, 1);
		chk("bcd_adjust", 16'(res), 16'h0020);
	endtask

	// An undefined form or an undefined opcode must be refused without starting a count.
	task automatic illegal_check;
		int k;
		int bn;
		logic il;
		seq_u.issue(4'h0, 3'h5, 8'h00, 8'h00, 8'h00, 16'h0, 1'b0, k, bn, il);
		chk("illegal", 16'({il, busy}), 16'h0002);
		seq_u.issue(4'hf, 3'h0, 8'h00, 8'h00, 8'h00, 16'h0, 1'b0, k, bn, il);
		chk("illegal_op", 16'({il, busy}), 16'h0002);
	endtask

	// A start raised while busy is ignored; the quotient still runs its six cycles.
	task automatic overlap_check;
		int k;
		seq_u.poke(8'h64, 8'h07, k);
		chk("overlap_cycles", 16'(k), 16'h0006);
		chk("overlap_result", {res_hi, res}, 16'h020e);
	endtask

	initial begin
		errors = 0;
		checks_done = 0;
		i_sys_rst = 1'b1;
		repeat (10) @(negedge i_mclk);
		i_sys_rst = 1'b0;
		timing_table();
		results_check();
		illegal_check();
		overlap_check();
		finish_test();
	end

	// The whole run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge i_mclk);
		errors++;
		finish_test();
	end
endmodule // arith_instr_timing_unit_tb_top
